// ===== scp_cfg.svh
// How it works
// R1: a protocol bit in the pin control register picks RS422/RS485 or RS232 operation of the transceivers.
// R2: bit 31 of the pin control register picks the terminal or data-set role, which sets the role-bound pin directions.
// R3: in terminal role the tx clock, tx data and request pins are outputs and the rx clock, rx data and clear pins inputs.
// R4: in data-set role those roles swap, the tx-side pins becoming inputs and the rx-side pins outputs.
// R5: bits 16:15 set the carrier-detect pin direction whatever the role.
// R6: bits 18:17 set the auxiliary clock pin direction whatever the role.
// R7: the transceiver enable bit turns the cable drivers on; while clear the channel drives nothing.
// R8: software sets transceiver enable and role before any data goes over the cable.
// R9: with external loopback the transmit signals leave on the role-chosen pins and the receive path reads those pins back.
// R10: internal loopback feeds the channel's transmit signals straight to its receive inputs, ignoring role.
// R11: during internal loopback with transceivers enabled the transmit data still appears on the role-chosen pins.
// R12: the pin status register shows only transceiver-side levels, never internally looped signals.
// R13: a cable signal used as a general-purpose output drives the value held in its pin control field.
// R14: every cable input level is readable in the pin status register.
// R15: the auxiliary clock pin is either an input taking an external clock or an output driving a clock.
// R16: while transceiver enable is clear every cable driver is high impedance, whatever role or loopback says.
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH

// ************************************************************
// register map
// ************************************************************
`define SCP_PIN_CTRL_OFS 8'h00
`define SCP_PIN_STAT_OFS 8'h04
`define SCP_PIN_CTRL_RST 32'h0000_0000

// ************************************************************
// pin control fields
// ************************************************************
`define SCP_ROLE_BIT 31
`define SCP_PROTO_BIT 30
`define SCP_XEN_BIT 29
`define SCP_EXTLB_BIT 28
`define SCP_INTLB_BIT 27
`define SCP_AUXDIR_HI 18
`define SCP_AUXDIR_LO 17
`define SCP_DCDDIR_HI 16
`define SCP_DCDDIR_LO 15
`define SCP_GSEL_HI 13
`define SCP_GSEL_LO 8
`define SCP_GVAL_HI 7
`define SCP_GVAL_LO 0

// direction field codes for carrier-detect and auxiliary clock
`define SCP_DIR_IN 2'h0
`define SCP_DIR_SRC 2'h1
`define SCP_DIR_GPO 2'h2

// ************************************************************
// cable pin indices
// ************************************************************
`define SCP_CABLE_TX_CLOCK_PIN 0
`define SCP_CABLE_RX_CLOCK_PIN 1
`define SCP_CABLE_TX_DATA_PIN 2
`define SCP_CABLE_RX_DATA_PIN 3
`define SCP_CABLE_TX_REQ_PIN 4
`define SCP_CABLE_RX_CLEAR_PIN 5
`define SCP_CABLE_CARRIER_PIN 6
`define SCP_CABLE_AUX_CLOCK_PIN 7

`endif

// ===== scp_pkg.sv
package scp_pkg;

  // ************************************************************
  // register-side state, pclk domain
  // ************************************************************
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] xfer;
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic [7:0] stat_s1;
    logic [7:0] stat_s2;
    logic [31:0] prdata;
  } scp_bus_st_t;

  // ************************************************************
  // cable-side state, link clock domain
  // ************************************************************
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic [31:0] cfg;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_o;
    logic [7:0] pin_oe;
    logic rx_clk;
    logic rx_data;
    logic rx_clear;
    logic carrier_in;
    logic aux_clk_in;
  } scp_link_st_t;

endpackage

// ===== scp_pin_steer.sv
// Added by the designer: the APB interface to the registers and the address map.
`include "scp_cfg.svh"

module scp_pin_steer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic proto_rs232,
  output logic xcvr_enable,
  input wire logic link_clk,
  input wire logic ctl_tx_clk,
  input wire logic ctl_tx_data,
  input wire logic ctl_tx_req,
  input wire logic ctl_carrier_out,
  input wire logic ctl_aux_clk_out,
  output logic ctl_rx_clk,
  output logic ctl_rx_data,
  output logic ctl_rx_clear,
  output logic ctl_carrier_in,
  output logic ctl_aux_clk_in,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe
);

  // ************************************************************
  // apb slave and registers, pclk domain
  // ************************************************************
  scp_pkg::scp_bus_st_t b_reg;
  scp_pkg::scp_bus_st_t b_next;
  scp_pkg::scp_link_st_t l_reg;
  scp_pkg::scp_link_st_t l_next;

  logic hit_ctrl;
  logic hit_stat;
  logic acc;

  always_comb begin
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    if (paddr == `SCP_PIN_CTRL_OFS) begin
      hit_ctrl = 1'b1;
    end else if (paddr == `SCP_PIN_STAT_OFS) begin
      hit_stat = 1'b1;
    end
  end

  assign acc = psel & penable;
  assign pready = acc;
  assign pslverr = acc & ~hit_ctrl & ~hit_stat;

  always_comb begin
    b_next = b_reg;
    // status crosses from the link domain as quasi-static levels
    b_next.stat_s1 = l_reg.pin_s2;
    b_next.stat_s2 = b_reg.stat_s1;
    if (acc && pwrite && hit_ctrl) begin
      b_next.ctrl = pwdata;
    end
    // a still copy of the control word goes to the link side under a four-phase
    // request and acknowledge, so no half-changed word reaches the pins; a write
    // that lands during a hand-over is sent by the next round
    b_next.ack_s1 = l_reg.req_s2;
    b_next.ack_s2 = b_reg.ack_s1;
    if (b_reg.req && b_reg.ack_s2) begin
      b_next.req = 1'b0;
    end else if (!b_reg.req && !b_reg.ack_s2 && (b_reg.xfer != b_reg.ctrl)) begin
      b_next.xfer = b_reg.ctrl;
      b_next.req = 1'b1;
    end
    // read data is captured in the setup cycle so it comes from a flop
    if (psel && !penable && !pwrite) begin
      if (hit_ctrl) begin
        b_next.prdata = b_reg.ctrl;
      end else if (hit_stat) begin
        b_next.prdata = {24'h00_0000, b_reg.stat_s2}; // R12 R14
      end else begin
        b_next.prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_reg <= '0;
      b_reg.ctrl <= `SCP_PIN_CTRL_RST;
      b_reg.xfer <= `SCP_PIN_CTRL_RST;
    end else begin
      b_reg <= b_next;
    end
  end

  assign prdata = b_reg.prdata;
  assign proto_rs232 = b_reg.ctrl[`SCP_PROTO_BIT]; // R1
  assign xcvr_enable = b_reg.ctrl[`SCP_XEN_BIT]; // R7

  // ************************************************************
  // link domain reset release
  // ************************************************************
  logic lrst_s1;
  logic link_rstn;

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      lrst_s1 <= 1'b0;
      link_rstn <= 1'b0;
    end else begin
      lrst_s1 <= 1'b1;
      link_rstn <= lrst_s1;
    end
  end

  // ************************************************************
  // cable steering, link clock domain
  // ************************************************************
  logic [31:0] cfg;
  logic role;
  logic xen;
  logic [1:0] dcd_dir;
  logic [1:0] aux_dir;
  logic [5:0] gsel;
  logic [7:0] gval;
  logic [7:0] out_dir;
  logic [7:0] drv;

  assign cfg = l_reg.cfg;
  assign role = cfg[`SCP_ROLE_BIT];
  assign xen = cfg[`SCP_XEN_BIT];
  assign dcd_dir = cfg[`SCP_DCDDIR_HI:`SCP_DCDDIR_LO];
  assign aux_dir = cfg[`SCP_AUXDIR_HI:`SCP_AUXDIR_LO];
  assign gsel = cfg[`SCP_GSEL_HI:`SCP_GSEL_LO];
  assign gval = cfg[`SCP_GVAL_HI:`SCP_GVAL_LO];

  always_comb begin
    l_next = l_reg;
    out_dir = 8'h00;
    drv = 8'h00;
    // the copy is taken only while the synced request stands, when it cannot move
    l_next.req_s1 = b_reg.req;
    l_next.req_s2 = l_reg.req_s1;
    if (l_reg.req_s2) begin
      l_next.cfg = b_reg.xfer; // R2
    end
    l_next.pin_s1 = pin_i;
    l_next.pin_s2 = l_reg.pin_s1;

    // role-bound pins
    out_dir[`SCP_CABLE_TX_CLOCK_PIN] = ~role; // R2 R3
    out_dir[`SCP_CABLE_TX_DATA_PIN] = ~role; // R3
    out_dir[`SCP_CABLE_TX_REQ_PIN] = ~role; // R3
    out_dir[`SCP_CABLE_RX_CLOCK_PIN] = role; // R4
    out_dir[`SCP_CABLE_RX_DATA_PIN] = role; // R4
    out_dir[`SCP_CABLE_RX_CLEAR_PIN] = role; // R4
    drv[`SCP_CABLE_TX_CLOCK_PIN] = ctl_tx_clk;
    drv[`SCP_CABLE_RX_CLOCK_PIN] = ctl_tx_clk;
    drv[`SCP_CABLE_TX_DATA_PIN] = ctl_tx_data;
    drv[`SCP_CABLE_RX_DATA_PIN] = ctl_tx_data;
    drv[`SCP_CABLE_TX_REQ_PIN] = ctl_tx_req;
    drv[`SCP_CABLE_RX_CLEAR_PIN] = ctl_tx_req;
    for (int i = 0; i < 6; i++) begin
      if (gsel[i]) begin
        out_dir[i] = 1'b1; // R13
        drv[i] = gval[i]; // R13
      end
    end

    // carrier detect and auxiliary clock ignore the role
    if (dcd_dir == `SCP_DIR_SRC) begin
      out_dir[`SCP_CABLE_CARRIER_PIN] = 1'b1; // R5
      drv[`SCP_CABLE_CARRIER_PIN] = ctl_carrier_out;
    end else if (dcd_dir == `SCP_DIR_GPO) begin
      out_dir[`SCP_CABLE_CARRIER_PIN] = 1'b1; // R5
      drv[`SCP_CABLE_CARRIER_PIN] = gval[`SCP_CABLE_CARRIER_PIN]; // R13
    end
    if (aux_dir == `SCP_DIR_SRC) begin
      out_dir[`SCP_CABLE_AUX_CLOCK_PIN] = 1'b1; // R6 R15
      drv[`SCP_CABLE_AUX_CLOCK_PIN] = ctl_aux_clk_out; // R15
    end else if (aux_dir == `SCP_DIR_GPO) begin
      out_dir[`SCP_CABLE_AUX_CLOCK_PIN] = 1'b1; // R6
      drv[`SCP_CABLE_AUX_CLOCK_PIN] = gval[`SCP_CABLE_AUX_CLOCK_PIN]; // R13
    end

    // loopback never touches the drivers, so with transceivers enabled pins show tx data in every loopback mode
    l_next.pin_o = drv; // R11
    l_next.pin_oe = xen ? out_dir : 8'h00; // R7 R16

    // receive path
    if (cfg[`SCP_INTLB_BIT]) begin
      l_next.rx_clk = ctl_tx_clk; // R10
      l_next.rx_data = ctl_tx_data; // R10
      l_next.rx_clear = ctl_tx_req; // R10
    end else if (cfg[`SCP_EXTLB_BIT]) begin
      l_next.rx_clk = role ? l_reg.pin_s2[`SCP_CABLE_RX_CLOCK_PIN] : l_reg.pin_s2[`SCP_CABLE_TX_CLOCK_PIN]; // R9
      l_next.rx_data = role ? l_reg.pin_s2[`SCP_CABLE_RX_DATA_PIN] : l_reg.pin_s2[`SCP_CABLE_TX_DATA_PIN]; // R9
      l_next.rx_clear = role ? l_reg.pin_s2[`SCP_CABLE_RX_CLEAR_PIN] : l_reg.pin_s2[`SCP_CABLE_TX_REQ_PIN]; // R9
    end else begin
      l_next.rx_clk = role ? l_reg.pin_s2[`SCP_CABLE_TX_CLOCK_PIN] : l_reg.pin_s2[`SCP_CABLE_RX_CLOCK_PIN]; // R3 R4
      l_next.rx_data = role ? l_reg.pin_s2[`SCP_CABLE_TX_DATA_PIN] : l_reg.pin_s2[`SCP_CABLE_RX_DATA_PIN]; // R3 R4
      l_next.rx_clear = role ? l_reg.pin_s2[`SCP_CABLE_TX_REQ_PIN] : l_reg.pin_s2[`SCP_CABLE_RX_CLEAR_PIN]; // R3 R4
    end
    l_next.carrier_in = l_reg.pin_s2[`SCP_CABLE_CARRIER_PIN];
    l_next.aux_clk_in = l_reg.pin_s2[`SCP_CABLE_AUX_CLOCK_PIN]; // R15
  end

  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      l_reg <= '0;
      l_reg.cfg <= `SCP_PIN_CTRL_RST;
    end else begin
      l_reg <= l_next;
    end
  end

  assign pin_o = l_reg.pin_o;
  assign pin_oe = l_reg.pin_oe;
  assign ctl_rx_clk = l_reg.rx_clk;
  assign ctl_rx_data = l_reg.rx_data;
  assign ctl_rx_clear = l_reg.rx_clear;
  assign ctl_carrier_in = l_reg.carrier_in;
  assign ctl_aux_clk_in = l_reg.aux_clk_in;

  // ************************************************************
  // checks, pclk domain
  // ************************************************************
  property p_proto_write;
    @(posedge pclk) disable iff (!presetn)
    (acc && pwrite && hit_ctrl) |=> (proto_rs232 == $past(pwdata[`SCP_PROTO_BIT]));
  endproperty
  a_proto_write: assert property (p_proto_write) else $error("protocol select not taken from write"); // R1

  property p_status_read;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_stat) |=> (prdata == {24'h00_0000, $past(b_reg.stat_s2)});
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read does not show cable levels"); // R14

  property p_status_follow;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |-> ##2 (b_reg.stat_s2 == $past(l_reg.pin_s2, 2));
  endproperty
  a_status_follow: assert property (p_status_follow) else $error("status not fed from transceiver side"); // R12

  property p_cfg_hold;
    @(posedge pclk) disable iff (!presetn)
    (b_reg.req || b_reg.ack_s2) |=> (b_reg.xfer == $past(b_reg.xfer));
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("control copy moved during hand-over"); // R2

  // ************************************************************
  // checks, link clock domain
  // ************************************************************
  property p_quiet_when_off;
    @(posedge link_clk) disable iff (!link_rstn)
    !xen |=> (pin_oe == 8'h00);
  endproperty
  a_quiet_when_off: assert property (p_quiet_when_off) else $error("driver on while transceivers off"); // R16

  property p_enable_drives;
    @(posedge link_clk) disable iff (!link_rstn)
    (xen && !role && gsel == 6'h00) |=> (pin_oe[5:0] == 6'h15);
  endproperty
  a_enable_drives: assert property (p_enable_drives) else $error("enabled channel not driving tx pins"); // R7

  property p_terminal_role;
    @(posedge link_clk) disable iff (!link_rstn)
    (xen && !role && !gsel[0] && !gsel[1])
      |=> (pin_oe[0] && !pin_oe[1] && pin_o[0] == $past(ctl_tx_clk));
  endproperty
  a_terminal_role: assert property (p_terminal_role) else $error("terminal role tx clock wrong"); // R3

  property p_dataset_role;
    @(posedge link_clk) disable iff (!link_rstn)
    (xen && role && gsel == 6'h00)
      |=> (pin_oe[5:0] == 6'h2a && pin_o[3] == $past(ctl_tx_data));
  endproperty
  a_dataset_role: assert property (p_dataset_role) else $error("data-set role directions wrong"); // R4

  property p_role_rx;
    @(posedge link_clk) disable iff (!link_rstn)
    (role && !cfg[`SCP_INTLB_BIT] && !cfg[`SCP_EXTLB_BIT]) |=> (ctl_rx_data == $past(l_reg.pin_s2[2]));
  endproperty
  a_role_rx: assert property (p_role_rx) else $error("data-set rx data not from tx data pin"); // R2

  property p_carrier_dir;
    @(posedge link_clk) disable iff (!link_rstn)
    (xen && dcd_dir == `SCP_DIR_IN) |=> !pin_oe[6];
  endproperty
  a_carrier_dir: assert property (p_carrier_dir) else $error("carrier pin driven while set as input"); // R5

  property p_aux_out;
    @(posedge link_clk) disable iff (!link_rstn)
    (xen && aux_dir == `SCP_DIR_SRC) |=> (pin_oe[7] && pin_o[7] == $past(ctl_aux_clk_out));
  endproperty
  a_aux_out: assert property (p_aux_out) else $error("aux clock not driven out"); // R6

  property p_aux_in;
    @(posedge link_clk) disable iff (!link_rstn)
    1'b1 |-> ##3 (ctl_aux_clk_in == $past(pin_i[7], 3));
  endproperty
  a_aux_in: assert property (p_aux_in) else $error("aux clock input not passed in"); // R15

  property p_ext_loop;
    @(posedge link_clk) disable iff (!link_rstn)
    (cfg[`SCP_EXTLB_BIT] && !cfg[`SCP_INTLB_BIT] && !role) |=> (ctl_rx_data == $past(l_reg.pin_s2[2]));
  endproperty
  a_ext_loop: assert property (p_ext_loop) else $error("external loopback not reading tx pin"); // R9

  property p_int_loop;
    @(posedge link_clk) disable iff (!link_rstn)
    cfg[`SCP_INTLB_BIT] |=> (ctl_rx_data == $past(ctl_tx_data) && ctl_rx_clear == $past(ctl_tx_req));
  endproperty
  a_int_loop: assert property (p_int_loop) else $error("internal loopback path broken"); // R10

  property p_int_loop_pins;
    @(posedge link_clk) disable iff (!link_rstn)
    (cfg[`SCP_INTLB_BIT] && xen && !role && !gsel[2]) |=> (pin_oe[2] && pin_o[2] == $past(ctl_tx_data));
  endproperty
  a_int_loop_pins: assert property (p_int_loop_pins) else $error("tx data missing on pin in internal loop"); // R11

  property p_gpo;
    @(posedge link_clk) disable iff (!link_rstn)
    (xen && gsel[4]) |=> (pin_oe[4] && pin_o[4] == $past(gval[4]));
  endproperty
  a_gpo: assert property (p_gpo) else $error("general output value not driven"); // R13

  property p_ext_loop_dataset;
    @(posedge link_clk) disable iff (!link_rstn)
    (cfg[`SCP_EXTLB_BIT] && !cfg[`SCP_INTLB_BIT] && role) |=> (ctl_rx_clear == $past(l_reg.pin_s2[5]));
  endproperty
  a_ext_loop_dataset: assert property (p_ext_loop_dataset) else $error("data-set loopback pin wrong"); // R9

  property p_rx_terminal;
    @(posedge link_clk) disable iff (!link_rstn)
    (!role && !cfg[`SCP_INTLB_BIT] && !cfg[`SCP_EXTLB_BIT]) |=> (ctl_rx_clk == $past(l_reg.pin_s2[1]));
  endproperty
  a_rx_terminal: assert property (p_rx_terminal) else $error("terminal rx clock not from rx clock pin"); // R3

  property p_carrier_src;
    @(posedge link_clk) disable iff (!link_rstn)
    (xen && dcd_dir == `SCP_DIR_SRC) |=> (pin_oe[6] && pin_o[6] == $past(ctl_carrier_out));
  endproperty
  a_carrier_src: assert property (p_carrier_src) else $error("carrier not driven from controller"); // R5

  property p_carrier_gpo;
    @(posedge link_clk) disable iff (!link_rstn)
    (xen && dcd_dir == `SCP_DIR_GPO) |=> (pin_oe[6] && pin_o[6] == $past(gval[6]));
  endproperty
  a_carrier_gpo: assert property (p_carrier_gpo) else $error("carrier general output value wrong"); // R13

  property p_aux_dir_in;
    @(posedge link_clk) disable iff (!link_rstn)
    (aux_dir != `SCP_DIR_SRC && aux_dir != `SCP_DIR_GPO) |=> !pin_oe[7];
  endproperty
  a_aux_dir_in: assert property (p_aux_dir_in) else $error("aux clock driven while set as input"); // R6

  property p_cfg_land;
    @(posedge link_clk) disable iff (!link_rstn)
    l_reg.req_s2 |=> (cfg == $past(b_reg.xfer));
  endproperty
  a_cfg_land: assert property (p_cfg_land) else $error("control word not taken on request"); // R2

  c_ext_loop: cover property (@(posedge link_clk) disable iff (!link_rstn) xen && cfg[`SCP_EXTLB_BIT]);
  c_int_loop: cover property (@(posedge link_clk) disable iff (!link_rstn) xen && cfg[`SCP_INTLB_BIT]);
  c_dataset: cover property (@(posedge link_clk) disable iff (!link_rstn) xen && role && pin_oe[1]);
  c_stat_read: cover property (@(posedge pclk) disable iff (!presetn) acc && !pwrite && hit_stat);
  c_gpo: cover property (@(posedge link_clk) disable iff (!link_rstn) xen && gsel != 6'h00);

endmodule // scp_pin_steer

// ===== scp_remote.sv
// ************************************************************
// remote serial equipment on the cable
// ************************************************************
module scp_remote (
  input wire logic link_clk,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] rem_val,
  input wire logic [7:0] rem_oe,
  output logic [7:0] pin_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] last_reg = 8'h00;

  // lines carry no pull, so a line nobody drives shows the inverse of its last level
  always @(posedge link_clk) begin
    last_reg <= pin_i;
  end

  // the channel's own driver wins; the remote only drives lines it was told to
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      pin_i[k] = pin_oe[k] ? pin_o[k] : (rem_oe[k] ? rem_val[k] : ~last_reg[k]);
    end
  end
endmodule // scp_remote

// ===== scp_pin_steer_bench.sv
// ************************************************************
// bench for the cable pin steering block
// ************************************************************
module scp_pin_steer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, link_clk = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, proto_rs232, xcvr_enable, err;
  logic ctl_tx_clk = 1'h0, ctl_tx_data = 1'h0, ctl_tx_req = 1'h0, ctl_carrier_out = 1'h0, ctl_aux_clk_out = 1'h0;
  logic ctl_rx_clk, ctl_rx_data, ctl_rx_clear, ctl_carrier_in, ctl_aux_clk_in;
  logic [7:0] pin_i, pin_o, pin_oe, rem_val = 8'h00, rem_oe = 8'h00;
  int fails = 0, compares = 0;

  always #5 pclk = ~pclk;
  // link edges fall on even ns, pclk rising edges on odd ns, so link edges never meet a pclk rising edge
  initial begin
    #2 link_clk = 1'h1;
    forever #32 link_clk = ~link_clk;
  end

  scp_pin_steer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .proto_rs232(proto_rs232), .xcvr_enable(xcvr_enable), .link_clk(link_clk), .ctl_tx_clk(ctl_tx_clk),
    .ctl_tx_data(ctl_tx_data), .ctl_tx_req(ctl_tx_req), .ctl_carrier_out(ctl_carrier_out),
    .ctl_aux_clk_out(ctl_aux_clk_out), .ctl_rx_clk(ctl_rx_clk), .ctl_rx_data(ctl_rx_data),
    .ctl_rx_clear(ctl_rx_clear), .ctl_carrier_in(ctl_carrier_in), .ctl_aux_clk_in(ctl_aux_clk_in),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));

  scp_remote remote (.link_clk(link_clk), .pin_o(pin_o), .pin_oe(pin_oe), .rem_val(rem_val),
    .rem_oe(rem_oe), .pin_i(pin_i));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task stop_test;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // no cycle limit here: a slave that never answers is caught by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  // config needs three link edges to cross, outputs one more; eight leaves margin for status too
  task setc(input logic [31:0] v);
    apb(1'h1, 8'h00, v);
    repeat (8) @(posedge link_clk);
    @(posedge pclk);
  endtask

  task drv(input logic [4:0] c, input logic [7:0] rv, input logic [7:0] ro);
    {ctl_aux_clk_out, ctl_carrier_out, ctl_tx_req, ctl_tx_data, ctl_tx_clk} <= c;
    rem_val <= rv;
    rem_oe <= ro;
    repeat (8) @(posedge link_clk);
    @(posedge pclk);
  endtask

  function automatic logic [7:0] spread(input logic [2:0] v);
    return {3'h0, v[2], 1'h0, v[1], 1'h0, v[0]};
  endfunction

  task path(input logic r, input logic [31:0] extra, input logic [2:0] c3, input logic [2:0] rx3,
            input logic [2:0] exp_rx, input logic remote_on);
    logic [7:0] txm, lvl, mask, ro;
    txm = r ? 8'h2a : 8'h15;
    ro = remote_on ? (~txm & 8'h3f) : 8'h00;
    mask = remote_on ? 8'h3f : txm;
    lvl = (spread(c3) << r) | (spread(rx3) << !r);
    setc({r, 31'h2000_0000} | extra);
    drv({2'h0, c3}, spread(rx3) << !r, ro);
    chk(32'(pin_oe), 32'(txm));
    chk(32'(pin_o & txm), 32'(spread(c3) << r));
    chk(32'({ctl_rx_clear, ctl_rx_data, ctl_rx_clk}), 32'(exp_rx));
    apb(1'h0, 8'h04, 32'h0);
    chk(rd & 32'(mask), 32'(lvl & mask));
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task t_regs;
    chk(32'(pin_oe), 32'h0);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    setc(32'h6000_0000);
    chk(32'({proto_rs232, xcvr_enable}), 32'h3);
    apb(1'h1, 8'h08, 32'hffff_ffff);
    chk(32'(err), 32'h1);
    apb(1'h0, 8'h08, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'h1, 8'h04, 32'hffff_ffff);
    chk(32'(err), 32'h0);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h6000_0000);
    setc(32'h2000_0000);
    chk(32'(proto_rs232), 32'h0);
  endtask

  task t_dirs;
    logic out;
    for (int i = 0; i < 8; i++) begin
      out = i[1] ^ i[0];
      setc({i[2], 31'h2000_0080} | (32'(i[1:0]) << 15) | (32'(i[1:0]) << 17));
      drv(5'h08, 8'h40, out ? 8'h00 : 8'hc0);
      chk(32'(pin_oe[7:6]), out ? 32'h3 : 32'h0);
      chk(32'(pin_oe[5:0]), i[2] ? 32'h2a : 32'h15);
      if (out)
        chk(32'(pin_o[7:6]), i[0] ? 32'h1 : 32'h2);
      else
        chk(32'({ctl_aux_clk_in, ctl_carrier_in}), 32'h1);
    end
  endtask

  task t_gpio;
    logic [7:0] v;
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'h12 : 8'h2d;
      setc(32'h2000_3f00 | 32'(v));
      drv(5'h00, 8'h00, 8'h00);
      chk(32'(pin_oe[5:0]), 32'h3f);
      chk(32'(pin_o[5:0]), 32'(v[5:0]));
      apb(1'h0, 8'h04, 32'h0);
      chk(rd & 32'h3f, 32'(v[5:0]));
    end
  endtask

  task t_off;
    setc(32'h9802_bfff);
    chk(32'({xcvr_enable, pin_oe}), 32'h0);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs;
    for (int r = 0; r < 2; r++) begin
      path(r[0], 32'h0, 3'h5, 3'h2, 3'h2, 1'h1);
      path(r[0], 32'h0, 3'h2, 3'h5, 3'h5, 1'h1);
      path(r[0], 32'h1000_0000, 3'h5, 3'h0, 3'h5, 1'h0);
      path(r[0], 32'h0800_0000, 3'h6, 3'h1, 3'h6, 1'h1);
    end
    t_dirs;
    t_gpio;
    t_off;
    stop_test;
  end

  // the full run needs roughly 20 us
  initial begin
    #300000;
    fails++;
    stop_test;
  end
endmodule // scp_pin_steer_bench
